// *** tat_consts.vh ***
// Purpose: constants for the asynchronous timer 0 block
// Assumes: byte addresses on a 32-bit Avalon-MM slave, one register per word
// Notes: only the low byte of each word is used, upper bits read as zero
`ifndef TAT_CONSTS_VH
`define TAT_CONSTS_VH

// register byte offsets
`define TAT_OFS_COUNT 5'h00
`define TAT_OFS_COMPARE 5'h04
`define TAT_OFS_CONTROL 5'h08
`define TAT_OFS_STATUS 5'h0C
`define TAT_OFS_MASK 5'h10
`define TAT_OFS_FLAGS 5'h14
`define TAT_OFS_SFC 5'h18

// async_timer_status fields
`define TAT_ST_ASYNC_SEL 3
`define TAT_ST_CNT_BUSY 2
`define TAT_ST_CMP_BUSY 1
`define TAT_ST_CTL_BUSY 0

// mask and flag fields
`define TAT_BIT_COMPARE 1
`define TAT_BIT_OVERFLOW 0

// special_function_control fields
`define TAT_SFC_SYNC_HOLD 7
`define TAT_SFC_PRESC_RST 1

// timer_control fields
`define TAT_CTL_WGM0 6
`define TAT_CTL_COM_HI 5
`define TAT_CTL_COM_LO 4
`define TAT_CTL_WGM1 3
`define TAT_CTL_CS_HI 2

// reset values
`define TAT_RST_BYTE 8'h00
`define TAT_RST_PRESC 10'h000

// counter limits
`define TAT_MAX 8'hFF
`define TAT_BOTTOM 8'h00

// waveform modes {wgm1, wgm0}
`define TAT_MODE_NORMAL 2'h0
`define TAT_MODE_PCPWM 2'h1
`define TAT_MODE_CTC 2'h2
`define TAT_MODE_FAST 2'h3

// processor cycles of flag synchronisation after the timer cycle
`define TAT_FLAG_SYNC_STAGES 3

`endif

// *** tat_async_timer0.v ***
// Purpose: timer 0 with asynchronous crystal clocking, holding registers,
//   update-busy flags, interrupt flags and prescaler
// Assumes: clk is the I/O clock; the crystal arrives on oscInPin and is
//   sampled here, so it must be well below a quarter of clk
// Notes: registers answer over Avalon-MM, one waitrequest cycle per access
//
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
`include "tat_consts.vh"

// How it works
// (RQ1) async select picks I/O or crystal clock
// (RQ2) counter write sets busy until loaded
// (RQ3) compare write sets busy until loaded
// (RQ4) control write sets busy until loaded
// (RQ5) software waits for busy clear before rewriting
// (RQ6) counter reads live value, others read holding
// (RQ7) holding registers load after two crystal edges
// (RQ8) no compare match while counter/compare pending
// (RQ9) wake logic needs one crystal cycle reset
// (RQ10) crystal stopped in power-down and standby
// (RQ11) wake starts on the next timer tick
// (RQ12) counter read register refreshed per crystal edge
// (RQ13) software syncs via busy flag before reading
// (RQ14) async flags take timer cycle plus three
// (RQ15) compare pin driven on timer tick directly
// (RQ16) compare irq needs global, enable and flag
// (RQ17) overflow irq needs global, enable and flag
// (RQ18) compare flag set on match, cleared twice
// (RQ19) overflow flag on wrap or bottom reversal
// (RQ20) prescaler taps 1,8,32,64,128,256,1024 or stop
// (RQ21) prescaler reset bit clears prescaler phase
// (RQ22) async select detaches crystal pins from port
// (RQ23) prescaler reset bit self-clear rules
module tat_async_timer0 (
  input wire clk, // I/O clock, 125 MHz
  input wire sys_rst, // asynchronous reset, active high
  input wire clkEn, // freezes all state while low
  input wire [4:0] avs_address, // byte address
  input wire avs_read, // read request
  input wire avs_write, // write request
  input wire [31:0] avs_writedata, // write data
  input wire [3:0] avs_byteenable, // byte lanes, lane 0 used
  output reg [31:0] avs_readdata, // read data
  output wire avs_waitrequest, // stall until answer
  input wire oscInPin, // crystal clock from the pin, asynchronous
  input wire globalIrqEnable, // global interrupt enable of the cpu status word
  input wire compareVecAck, // compare vector executing, one-cycle pulse
  input wire overflowVecAck, // overflow vector executing, one-cycle pulse
  input wire sleepActive, // processor in power-save style sleep
  input wire deepSleep, // power-down or standby selected
  output wire compareIrq, // compare-match interrupt request
  output wire overflowIrq, // overflow interrupt request
  output reg wakeReq, // wake-up request from sleep
  output reg compareOut, // compare output pin level
  output wire oscPinsDetach, // crystal pins taken from the port
  output wire oscEnable // crystal oscillator running
);

  // bus handshake state
  reg ackR;
  wire busReq;
  wire busWr;
  wire [7:0] wrByte;
  // crystal sampling
  reg oscS1_r;
  reg oscS2_r;
  reg oscS3_r;
  reg oscLevel_r;
  wire oscRise;
  // control and status
  reg asyncSel_r;
  reg [7:0] mask_r;
  reg [1:0] flags_r;
  reg syncHold_r;
  reg prescRst_r;
  reg [9:0] presc_r;
  reg [7:0] count_r;
  reg [7:0] compare_r;
  reg [7:0] control_r;
  reg countSync_r;
  reg [7:0] countRead_r;
  reg dirDown_r;
  reg [1:0] evtPend_r;
  reg [1:0] evtPipe0_r;
  reg [1:0] evtPipe1_r;
  reg [1:0] evtPipe2_r;
  reg wakeBlock_r;
  // per-register holding channels
  wire [2:0] busyVec;
  wire [2:0] loadVec;
  wire [23:0] holdFlat;
  wire [23:0] loadFlat;
  // timing
  wire srcTick;
  reg cntTick;
  wire [1:0] mode;
  wire matchNow;
  reg [1:0] evtNow;
  wire [1:0] flagSet, flagClr;
  reg [7:0] rdByte;

  // one wait cycle per access, request taken when ackR is high
  assign busReq = avs_read | avs_write;
  assign avs_waitrequest = busReq & ~ackR;
  assign busWr = avs_write & ackR & clkEn & avs_byteenable[0];
  assign wrByte = avs_writedata[7:0];

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ackR <= 1'b0;
    end else if (clkEn) begin
      ackR <= busReq & ~ackR;
    end
  end

  // crystal input: three flops, edge counts once stages two and three agree
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      oscS1_r <= 1'b0;
      oscS2_r <= 1'b0;
      oscS3_r <= 1'b0;
      oscLevel_r <= 1'b0;
    end else if (clkEn) begin
      oscS1_r <= oscInPin;
      oscS2_r <= oscS1_r;
      oscS3_r <= oscS2_r;
      if (oscS2_r == oscS3_r) begin
        oscLevel_r <= oscS3_r;
      end
    end
  end

  // a stopped oscillator gives no edges in deep sleep
  assign oscEnable = asyncSel_r & ~deepSleep; // RQ10
  assign oscRise = oscEnable & (oscS2_r == oscS3_r) & oscS3_r & ~oscLevel_r;
  assign srcTick = asyncSel_r ? oscRise : 1'b1; // RQ1
  assign oscPinsDetach = asyncSel_r; // RQ22

  // holding register, busy flag and edge count for each of the three registers
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : chan
      localparam [4:0] OFS = (gi == 0) ? `TAT_OFS_COUNT :
                             (gi == 1) ? `TAT_OFS_COMPARE : `TAT_OFS_CONTROL;
      reg [7:0] hold_r;
      reg busy_r;
      reg edgeSeen_r;
      wire wr;
      assign wr = busWr & (avs_address == OFS);
      // sync mode loads at once; async waits for the second crystal edge
      assign loadVec[gi] = (wr & ~asyncSel_r) | (busy_r & oscRise & edgeSeen_r); // RQ7
      assign loadFlat[gi*8 +: 8] = asyncSel_r ? hold_r : wrByte;
      assign holdFlat[gi*8 +: 8] = hold_r;
      assign busyVec[gi] = busy_r;
      always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          hold_r <= `TAT_RST_BYTE;
          busy_r <= 1'b0;
          edgeSeen_r <= 1'b0;
        end else if (clkEn) begin
          if (wr) begin
            // a rewrite while busy restarts the transfer; the value may tear
            hold_r <= wrByte; // RQ5
            busy_r <= asyncSel_r; // RQ2 RQ3 RQ4
            edgeSeen_r <= 1'b0;
          end else if (busy_r && oscRise) begin
            if (edgeSeen_r) begin
              busy_r <= 1'b0; // RQ2 RQ3 RQ4
              edgeSeen_r <= 1'b0;
            end else begin
              edgeSeen_r <= 1'b1; // RQ7
            end
          end
        end
      end
    end
  endgenerate

  // async select, interrupt mask, sync hold and prescaler reset bits
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      asyncSel_r <= 1'b0;
      mask_r <= `TAT_RST_BYTE;
      syncHold_r <= 1'b0;
      prescRst_r <= 1'b0;
    end else if (clkEn) begin
      if (busWr && avs_address == `TAT_OFS_STATUS) begin
        asyncSel_r <= wrByte[`TAT_ST_ASYNC_SEL]; // RQ1
      end
      if (busWr && avs_address == `TAT_OFS_MASK) begin
        mask_r <= wrByte;
      end
      if (busWr && avs_address == `TAT_OFS_SFC) begin
        syncHold_r <= wrByte[`TAT_SFC_SYNC_HOLD];
        if (wrByte[`TAT_SFC_PRESC_RST]) begin
          prescRst_r <= 1'b1; // RQ21
        end
      end else if (prescRst_r && !syncHold_r) begin
        // async mode holds the bit until a crystal edge has reset the prescaler
        if (!asyncSel_r || oscRise) begin
          prescRst_r <= 1'b0; // RQ23
        end
      end
    end
  end

  // prescaler counts source ticks, held at zero while reset is asserted
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      presc_r <= `TAT_RST_PRESC;
    end else if (clkEn) begin
      if (prescRst_r) begin
        presc_r <= `TAT_RST_PRESC; // RQ21
      end else if (srcTick) begin
        presc_r <= presc_r + 10'h001;
      end
    end
  end

  // clock select decode of prescaler taps
  always @* begin
    case (control_r[`TAT_CTL_CS_HI:0])
      3'h1: cntTick = srcTick; // RQ20
      3'h2: cntTick = srcTick & (&presc_r[2:0]);
      3'h3: cntTick = srcTick & (&presc_r[4:0]);
      3'h4: cntTick = srcTick & (&presc_r[5:0]);
      3'h5: cntTick = srcTick & (&presc_r[6:0]);
      3'h6: cntTick = srcTick & (&presc_r[7:0]);
      3'h7: cntTick = srcTick & (&presc_r[9:0]);
      default: cntTick = 1'b0;
    endcase
    if (prescRst_r) begin
      cntTick = 1'b0;
    end
  end

  assign mode = {control_r[`TAT_CTL_WGM1], control_r[`TAT_CTL_WGM0]};
  // pending counter or compare transfer masks the comparator
  assign matchNow = (count_r == compare_r) & ~busyVec[0] & ~busyVec[1]; // RQ8

  // events raised on this counter tick
  always @* begin
    evtNow = 2'h0;
    if (cntTick && !loadVec[0]) begin
      evtNow[`TAT_BIT_COMPARE] = matchNow; // RQ18
      if (mode == `TAT_MODE_PCPWM) begin
        evtNow[`TAT_BIT_OVERFLOW] = dirDown_r & (count_r == `TAT_BOTTOM); // RQ19
      end else begin
        evtNow[`TAT_BIT_OVERFLOW] = (count_r == `TAT_MAX); // RQ19
      end
    end
  end

  // destination registers and the counter itself
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_r <= `TAT_RST_BYTE;
      compare_r <= `TAT_RST_BYTE;
      control_r <= `TAT_RST_BYTE;
      dirDown_r <= 1'b0;
      compareOut <= 1'b0;
    end else if (clkEn) begin
      if (loadVec[1]) begin
        compare_r <= loadFlat[15:8]; // RQ3
      end
      if (loadVec[2]) begin
        control_r <= loadFlat[23:16]; // RQ4
      end
      if (loadVec[0]) begin
        count_r <= loadFlat[7:0]; // RQ2
      end else if (cntTick) begin
        case (mode)
          `TAT_MODE_CTC: begin
            count_r <= matchNow ? `TAT_BOTTOM : count_r + 8'h01;
          end
          `TAT_MODE_PCPWM: begin
            if (!dirDown_r && count_r == `TAT_MAX) begin
              dirDown_r <= 1'b1;
              count_r <= count_r - 8'h01;
            end else if (dirDown_r && count_r == `TAT_BOTTOM) begin
              dirDown_r <= 1'b0;
              count_r <= count_r + 8'h01;
            end else begin
              count_r <= dirDown_r ? count_r - 8'h01 : count_r + 8'h01;
            end
          end
          default: begin
            count_r <= count_r + 8'h01;
          end
        endcase
      end
      // pin follows the timer tick with no resync to the processor clock
      if (cntTick && matchNow && !loadVec[0]) begin
        case ({control_r[`TAT_CTL_COM_HI], control_r[`TAT_CTL_COM_LO]})
          2'h1: compareOut <= ~compareOut; // RQ15
          2'h2: compareOut <= 1'b0;
          2'h3: compareOut <= 1'b1;
          default: compareOut <= compareOut;
        endcase
      end
    end
  end

  // async flags: held one timer cycle, then three processor stages
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      evtPend_r <= 2'h0;
      evtPipe0_r <= 2'h0;
      evtPipe1_r <= 2'h0;
      evtPipe2_r <= 2'h0;
    end else if (clkEn) begin
      if (srcTick) begin
        evtPipe0_r <= evtPend_r; // RQ14
        evtPend_r <= evtNow;
      end else begin
        evtPipe0_r <= 2'h0;
        evtPend_r <= evtPend_r | evtNow;
      end
      evtPipe1_r <= evtPipe0_r;
      evtPipe2_r <= evtPipe1_r;
    end
  end

  assign flagSet = asyncSel_r ? evtPipe2_r : evtNow; // RQ14

  // interrupt flags: set wins over write-one-to-clear and vector clear
  assign flagClr = ({2{busWr && avs_address == `TAT_OFS_FLAGS}} & wrByte[1:0]) |
                   {compareVecAck, overflowVecAck}; // RQ18 RQ19
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_r <= 2'h0;
    end else if (clkEn) begin
      flags_r <= (flags_r & ~flagClr) | flagSet;
    end
  end

  assign compareIrq = globalIrqEnable & mask_r[`TAT_BIT_COMPARE] &
                      flags_r[`TAT_BIT_COMPARE]; // RQ16
  assign overflowIrq = globalIrqEnable & mask_r[`TAT_BIT_OVERFLOW] &
                       flags_r[`TAT_BIT_OVERFLOW]; // RQ17

  // wake request on the next timer tick; blocked after it until a crystal rise once awake
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wakeReq <= 1'b0;
      wakeBlock_r <= 1'b0;
    end else if (clkEn) begin
      if (!sleepActive) begin
        wakeReq <= 1'b0;
      end else if (srcTick && (compareIrq || overflowIrq) && !wakeBlock_r) begin
        wakeReq <= 1'b1; // RQ11
        wakeBlock_r <= 1'b1;
      end
      if (wakeBlock_r && !sleepActive && oscRise) begin
        wakeBlock_r <= 1'b0; // RQ9
      end
    end
  end

  // counter read copy; frozen in sleep so the old value shows after wake
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      countRead_r <= `TAT_RST_BYTE;
      countSync_r <= 1'b0;
    end else if (clkEn) begin
      countSync_r <= asyncSel_r;
      if (!sleepActive && (!asyncSel_r || oscRise || !countSync_r)) begin
        countRead_r <= count_r; // RQ12
      end
    end
  end

  // read mux; unmapped addresses read zero
  always @* begin
    case (avs_address)
      `TAT_OFS_COUNT: rdByte = asyncSel_r ? countRead_r : count_r; // RQ6
      `TAT_OFS_COMPARE: rdByte = holdFlat[15:8]; // RQ6
      `TAT_OFS_CONTROL: rdByte = {1'b0, holdFlat[22:16]};
      `TAT_OFS_STATUS: rdByte = {4'h0, asyncSel_r, busyVec[0], busyVec[1], busyVec[2]};
      `TAT_OFS_MASK: rdByte = mask_r;
      `TAT_OFS_FLAGS: rdByte = {6'h00, flags_r};
      `TAT_OFS_SFC: rdByte = {syncHold_r, 5'h00, prescRst_r, 1'b0};
      default: rdByte = 8'h00;
    endcase
  end

  // read data captured in the wait cycle, stands at the answer edge
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= 32'h00000000;
    end else if (clkEn) begin
      if (avs_read && !ackR) begin
        avs_readdata <= {24'h000000, rdByte};
      end
    end
  end

endmodule // tat_async_timer0
`default_nettype wire

// *** tat_async_timer0_sva.sv ***
// Purpose: port-level checks of the async timer 0 block
// Assumes: one clock domain, reset active high
// Notes: wait and wake-drop checks only hold while clkEn runs
`timescale 1ns/1ns
`default_nettype none
module tat_timer_chk (
  input wire clk, // I/O clock
  input wire sys_rst, // async reset
  input wire clkEn, // clock enable
  input wire avs_read, // read request
  input wire avs_write, // write request
  input wire [31:0] avs_readdata, // read data
  input wire avs_waitrequest, // stall
  input wire globalIrqEnable, // global enable
  input wire sleepActive, // sleeping
  input wire deepSleep, // oscillator stopped
  input wire compareIrq, // compare irq
  input wire overflowIrq, // overflow irq
  input wire wakeReq, // wake request
  input wire oscPinsDetach, // pins detached
  input wire oscEnable // oscillator on
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // an irq never leaks past the global enable
  property p_cmpGlob; compareIrq |-> globalIrqEnable; endproperty
  a_cmpGlob: assert property (p_cmpGlob) else $error("compare irq without global");
  property p_ovfGlob; overflowIrq |-> globalIrqEnable; endproperty
  a_ovfGlob: assert property (p_ovfGlob) else $error("overflow irq without global");
  // oscillator follows async select except in deep sleep
  property p_oscDeep; deepSleep |-> !oscEnable; endproperty
  a_oscDeep: assert property (p_oscDeep) else $error("osc runs in deep sleep");
  property p_detach; !deepSleep |-> oscEnable == oscPinsDetach; endproperty
  a_detach: assert property (p_detach) else $error("osc and pin detach differ");
  // wake only from sleep, dropped once awake
  property p_wakeDrop; !sleepActive && clkEn |=> !wakeReq; endproperty
  a_wakeDrop: assert property (p_wakeDrop) else $error("wake held while awake");
  property p_wakeRise; $rose(wakeReq) |-> $past(sleepActive); endproperty
  a_wakeRise: assert property (p_wakeRise) else $error("wake raised while awake");
  // at most one wait cycle, byte-wide read data
  property p_oneWait; (avs_read || avs_write) && avs_waitrequest && clkEn |=> !avs_waitrequest;
  endproperty
  a_oneWait: assert property (p_oneWait) else $error("waitrequest longer than one");
  property p_rdHigh; avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000;
  endproperty
  a_rdHigh: assert property (p_rdHigh) else $error("read data upper bits set");
endmodule // tat_timer_chk
bind tat_async_timer0 tat_timer_chk u_chk (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .globalIrqEnable(globalIrqEnable),
  .sleepActive(sleepActive), .deepSleep(deepSleep), .compareIrq(compareIrq),
  .overflowIrq(overflowIrq), .wakeReq(wakeReq), .oscPinsDetach(oscPinsDetach),
  .oscEnable(oscEnable));
`default_nettype wire

// *** tb_top.sv ***
// Purpose: self-checking bench of the async timer 0 block
// Assumes: crystal modelled as a 40-cycle square wave
// Notes: all register traffic through Avalon-MM tasks
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 1'b0, sysRst = 1'b1, rd = 1'b0, wr = 1'b0, osc = 1'b0;
  logic glob = 1'b0, cva = 1'b0, ova = 1'b0, sleep = 1'b0, deep = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [7:0] v;
  wire [31:0] rdata;
  wire wreq, cIrq, oIrq, wake, detach, oscEn, cOut;
  int miscompares = 0, samples_checked = 0, cyc = 0, oscCnt = 0, t0, div;

  tat_async_timer0 dut (.clk(clk), .sys_rst(sysRst), .clkEn(1'b1), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'hF),
    .avs_readdata(rdata), .avs_waitrequest(wreq), .oscInPin(osc), .globalIrqEnable(glob),
    .compareVecAck(cva), .overflowVecAck(ova), .sleepActive(sleep), .deepSleep(deep),
    .compareIrq(cIrq), .overflowIrq(oIrq), .wakeReq(wake), .compareOut(cOut),
    .oscPinsDetach(detach), .oscEnable(oscEn));

  always #4 clk = ~clk;
  // crystal stands still while deep sleep is selected
  always @(posedge clk) begin
    oscCnt <= (oscCnt == 19) ? 0 : oscCnt + 1;
    if (oscCnt == 19 && !deep) osc <= ~osc;
  end
  // hang guard, well above the expected run
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // request held until the rising edge after waitrequest is seen low at a falling edge
  task automatic bus(input logic isWr, input logic [4:0] a, input logic [31:0] d);
    logic w;
    @(posedge clk);
    rd <= !isWr;
    wr <= isWr;
    addr <= a;
    wdata <= d;
    do begin
      @(negedge clk);
      w = wreq;
      @(posedge clk);
    end while (w !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wrt(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h000000, d});
  endtask
  task automatic rdv(input logic [4:0] a, output logic [7:0] d);
    bus(1'b0, a, 32'h00000000);
    d = rdata[7:0];
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 32'h00000000);
    chk(rdata, {24'h000000, e});
  endtask
  task automatic pulse(input logic isCmp);
    @(posedge clk);
    if (isCmp) cva <= 1'b1;
    else ova <= 1'b1;
    @(posedge clk);
    cva <= 1'b0;
    ova <= 1'b0;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    sysRst <= 1'b0;
    // reset values, then read-only busy bits and an unmapped word
    for (int i = 0; i < 7; i++) rdc(5'(i * 4), 8'h00);
    chk(cOut, 1'b0);
    wrt(5'h0C, 8'h07);
    rdc(5'h0C, 8'h00);
    wrt(5'h1C, 8'hFF);
    rdc(5'h1C, 8'h00);
    wrt(5'h04, 8'h80);
    rdc(5'h04, 8'h80);
    rdc(5'h0C, 8'h00);
    wrt(5'h10, 8'h03);
    $display("test access done");
    // overflow flag, its irq gating and clear by writing one
    wrt(5'h00, 8'hFE);
    wrt(5'h08, 8'h01);
    repeat (10) @(posedge clk);
    wrt(5'h08, 8'h00);
    rdc(5'h14, 8'h01);
    glob <= 1'b1;
    @(posedge clk);
    chk(oIrq, 1'b1);
    chk(cIrq, 1'b0);
    glob <= 1'b0;
    @(posedge clk);
    chk(oIrq, 1'b0);
    wrt(5'h14, 8'h01);
    rdc(5'h14, 8'h00);
    // compare flag, masked irq, clear by vector
    wrt(5'h04, 8'h10);
    wrt(5'h00, 8'h0E);
    wrt(5'h08, 8'h31);
    repeat (6) @(posedge clk);
    wrt(5'h08, 8'h00);
    rdc(5'h14, 8'h02);
    chk(cOut, 1'b1);
    glob <= 1'b1;
    @(posedge clk);
    chk(cIrq, 1'b1);
    wrt(5'h10, 8'h01);
    @(negedge clk);
    chk(cIrq, 1'b0);
    pulse(1'b1);
    rdc(5'h14, 8'h00);
    pulse(1'b0);
    // phase-correct: no overflow at the top, overflow on reversal at bottom
    wrt(5'h00, 8'hFD);
    wrt(5'h08, 8'h41);
    repeat (20) @(posedge clk);
    rdv(5'h14, v);
    chk(v[0], 1'b0);
    repeat (260) @(posedge clk);
    wrt(5'h08, 8'h00);
    rdv(5'h14, v);
    chk(v[0], 1'b1);
    wrt(5'h14, 8'h03);
    $display("test flags done");
    // prescaler taps /8 and /32 from a reset phase
    for (int k = 2; k < 4; k++) begin
      div = (k == 2) ? 8 : 32;
      wrt(5'h18, 8'h02);
      wrt(5'h00, 8'h00);
      wrt(5'h08, 8'(k));
      repeat (10 * div) @(posedge clk);
      wrt(5'h08, 8'h00);
      rdv(5'h00, v);
      chk(v >= 8'h09 && v <= 8'h0B, 1'b1);
    end
    // sync hold keeps the prescaler reset and the counter halted
    wrt(5'h18, 8'h82);
    wrt(5'h00, 8'h20);
    wrt(5'h08, 8'h01);
    repeat (20) @(posedge clk);
    rdc(5'h00, 8'h20);
    rdc(5'h18, 8'h82);
    wrt(5'h08, 8'h00);
    wrt(5'h18, 8'h02);
    rdc(5'h18, 8'h00);
    $display("test prescaler done");
    // async: busy per register until two crystal rises
    wrt(5'h0C, 8'h08);
    @(negedge clk);
    chk({detach, oscEn}, 2'b11);
    for (int j = 0; j < 3; j++) begin
      t0 = cyc;
      wrt(5'(j * 4), 8'h05);
      rdc(5'h0C, 8'h08 | (8'h04 >> j));
      do rdv(5'h0C, v); while (v[2:0] != 3'h0 && cyc - t0 < 400);
      chk(v, 8'h08);
      chk(cyc - t0 >= 40, 1'b1);
      if (j > 0) rdc(5'(j * 4), 8'h05);
      if (j == 1) rdc(5'h00, 8'h05);
    end
    // timer overflow wakes the sleeping processor
    wrt(5'h08, 8'h01);
    wrt(5'h00, 8'hFE);
    repeat (100) @(posedge clk);
    sleep <= 1'b1;
    for (int n = 0; n < 600 && wake !== 1'b1; n++) @(posedge clk);
    chk(wake, 1'b1);
    sleep <= 1'b0;
    deep <= 1'b1;
    @(posedge clk);
    chk(oscEn, 1'b0);
    deep <= 1'b0;
    $display("test async done");
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
